/* File: verilog/kmn_navigator.sv */
// Function
// - codes classed into groups by leading character
// - program LED lit for parameter groups only
// - cancel on code: first of next group
// - cancel on data: drop edit, show code
// - set on code: show data
// - set on data: store, show code
// - cancel held over 1s: first monitor item
// - cancel held jumps once per hold, no repeat
// - monitor values cannot be edited
// - main profile edits apply live, except one
`timescale 1ns/1ps
`default_nettype none
module kmn_navigator (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // front-panel keys (asynchronous pins)
  input wire kmn_pkg::kmn_keys_t keys_pin,
  // monitor values shown for the monitor group
  input wire logic [kmn_pkg::KMN_DATA_W-1:0] monitor_value,
  // display content
  output kmn_pkg::kmn_code_t disp_code,
  output logic disp_is_data,
  output logic [kmn_pkg::KMN_DATA_W-1:0] disp_value,
  // panel indicator
  output logic program_mode_indicator,
  // values in force for operation
  output logic [kmn_pkg::KMN_ADDR_W-1:0] op_addr,
  output logic [kmn_pkg::KMN_DATA_W-1:0] op_value,
  output logic op_write
);
  import kmn_pkg::*;

  // ********************************
  // key conditioning
  // ********************************
  kmn_keys_t lvl, prs;

  kmn_key_edge u_keys (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .keys_pin(keys_pin),
    .keys_level(lvl),
    .keys_press(prs)
  );

  // ********************************
  // navigation state
  // ********************************
  typedef enum logic [1:0] {
    KMN_ST_CODE,  // function code shown
    KMN_ST_DATA   // data value shown
  } kmn_state_t;

  kmn_state_t st_q, st_d;
  kmn_code_t code_q, code_d;
  logic [KMN_DATA_W-1:0] edit_q, edit_d;       // pending value
  logic [KMN_HOLD_W-1:0] hold_q, hold_d;       // cancel hold counter
  logic hold_done_q, hold_done_d;              // one jump per hold
  logic [KMN_DATA_W-1:0] wr_val_q, wr_val_d;   // operation write data
  logic [KMN_ADDR_W-1:0] wr_adr_q, wr_adr_d;
  logic wr_q, wr_d;

  // stored parameter values, one word per code
  logic [KMN_DATA_W-1:0] store_q [0:(1<<KMN_ADDR_W)-1];
  // one bit per word: never-stored words read as the reset value, not unknown
  logic [(1<<KMN_ADDR_W)-1:0] written_q;
  logic [KMN_DATA_W-1:0] store_rd; // stored value of the shown code
  logic commit;                    // set on data view stores this cycle

  logic [KMN_ADDR_W-1:0] cur_addr;
  logic is_monitor;
  logic live_edit;

  // address and group class of the shown code
  always_comb begin
    cur_addr = {code_q.group[2:0], code_q.item};
    is_monitor = (code_q.group == KMN_GRP_MON);
    live_edit = (code_q.group == KMN_GRP_MAIN) && (code_q.item != KMN_EXCLUDED_ITEM);
    store_rd = written_q[cur_addr] ? store_q[cur_addr] : KMN_DATA_RST;
    commit = prs.set_key && !prs.cancel_key && st_q == KMN_ST_DATA && !is_monitor
      && !(lvl.cancel_key && !hold_done_q && hold_q == KMN_HOLD_W'(KMN_HOLD_CYC));
  end

  // ********************************
  // next-state logic
  // ********************************
  // cancel has priority over set, set over up/down
  always_comb begin
    st_d = st_q;
    code_d = code_q;
    edit_d = edit_q;
    hold_d = hold_q;
    hold_done_d = hold_done_q;
    wr_d = 1'b0;
    wr_val_d = wr_val_q;
    wr_adr_d = wr_adr_q;
    // hold counter runs only while cancel is down
    if (lvl.cancel_key) begin
      if (hold_q < KMN_HOLD_W'(KMN_HOLD_CYC)) begin
        hold_d = hold_q + 1'b1;
      end
    end else begin
      hold_d = '0;
      hold_done_d = 1'b0;
    end
    if (lvl.cancel_key && !hold_done_q && hold_q == KMN_HOLD_W'(KMN_HOLD_CYC)) begin
      // long hold wins over anything shown
      st_d = KMN_ST_CODE;
      code_d.group = KMN_GRP_MON;
      code_d.item = KMN_FIRST_ITEM;
      hold_done_d = 1'b1;
    end else if (prs.cancel_key) begin
      if (st_q == KMN_ST_CODE) begin
        // wrap from the last group back to the monitor group
        code_d.group = (code_q.group == KMN_GRP_USER) ? KMN_GRP_MON
          : kmn_group_t'(code_q.group + 4'h1);
        code_d.item = KMN_FIRST_ITEM;
      end else begin
        st_d = KMN_ST_CODE;
        if (live_edit) begin
          // live edit is undone by restoring the stored value
          wr_d = 1'b1;
          wr_adr_d = cur_addr;
          wr_val_d = store_rd;
        end
      end
    end else if (prs.set_key) begin
      if (st_q == KMN_ST_CODE) begin
        st_d = KMN_ST_DATA;
        edit_d = is_monitor ? monitor_value : store_rd;
      end else begin
        st_d = KMN_ST_CODE;
        if (!is_monitor) begin
          wr_d = 1'b1;
          wr_adr_d = cur_addr;
          wr_val_d = edit_q;
        end
      end
    end else if (prs.up_key || prs.down_key) begin
      if (st_q == KMN_ST_CODE) begin
        // item steps within the group, wrapping
        if (prs.up_key) begin
          code_d.item = (code_q.item == KMN_ITEMS_PER_GROUP - 4'h1) ? '0
            : code_q.item + 4'h1;
        end else begin
          code_d.item = (code_q.item == '0) ? KMN_ITEMS_PER_GROUP - 4'h1
            : code_q.item - 4'h1;
        end
      end else if (!is_monitor) begin
        edit_d = prs.up_key ? edit_q + 1'b1 : edit_q - 1'b1;
        if (live_edit) begin
          wr_d = 1'b1;
          wr_adr_d = cur_addr;
          wr_val_d = edit_d;
        end
      end
    end
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= KMN_ST_CODE;
      code_q <= '{group: KMN_GRP_MON, item: KMN_FIRST_ITEM};
      edit_q <= KMN_DATA_RST;
      hold_q <= '0;
      hold_done_q <= 1'b0;
      wr_q <= 1'b0;
      wr_val_q <= KMN_DATA_RST;
      wr_adr_q <= '0;
    end else begin
      st_q <= st_d;
      code_q <= code_d;
      edit_q <= edit_d;
      hold_q <= hold_d;
      hold_done_q <= hold_done_d;
      wr_q <= wr_d;
      wr_val_q <= wr_val_d;
      wr_adr_q <= wr_adr_d;
    end
  end

  // value store: committed on set only; no reset, a memory array
  always_ff @(posedge clk_sys) begin
    if (commit) begin
      store_q[cur_addr] <= edit_q;
    end
  end

  // written marks: reset clears them, a commit sets its word's bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      written_q <= '0;
    end else if (commit) begin
      written_q[cur_addr] <= 1'b1;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign disp_code = code_q;
  assign disp_is_data = (st_q == KMN_ST_DATA);
  assign disp_value = is_monitor ? monitor_value : edit_q;
  assign program_mode_indicator = !is_monitor;
  assign op_addr = wr_adr_q;
  assign op_value = wr_val_q;
  assign op_write = wr_q;

  // ********************************
  // checks
  // ********************************
  a_led_group: assert property (@(posedge clk_sys) disable iff (!rst_n)
    program_mode_indicator == (disp_code.group != KMN_GRP_MON))
    else $error("program led wrong for group");

  a_cancel_next: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (prs.cancel_key && st_q == KMN_ST_CODE && hold_q != KMN_HOLD_W'(KMN_HOLD_CYC))
    |=> code_q.item == KMN_FIRST_ITEM && code_q.group != $past(code_q.group))
    else $error("cancel did not advance group");

  a_cancel_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (prs.cancel_key && st_q == KMN_ST_DATA) |=> st_q == KMN_ST_CODE)
    else $error("cancel did not leave data");

  a_set_enter: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (prs.set_key && !lvl.cancel_key && st_q == KMN_ST_CODE) |=> st_q == KMN_ST_DATA)
    else $error("set did not enter data");

  a_set_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (prs.set_key && !lvl.cancel_key && st_q == KMN_ST_DATA && !is_monitor)
    |=> op_write && op_value == $past(edit_q) && st_q == KMN_ST_CODE)
    else $error("set did not store value");

  a_hold_jump: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lvl.cancel_key && !hold_done_q && hold_q == KMN_HOLD_W'(KMN_HOLD_CYC))
    |=> code_q.group == KMN_GRP_MON && code_q.item == KMN_FIRST_ITEM && hold_done_q)
    else $error("long cancel did not reach first monitor");

  a_hold_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (lvl.cancel_key && hold_q < KMN_HOLD_W'(KMN_HOLD_CYC)) |=> hold_q == $past(hold_q) + 1'b1)
    else $error("hold counter stalled");

  a_mon_ro: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == KMN_ST_DATA && is_monitor) |=> !op_write)
    else $error("monitor value written");

  a_live_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (prs.up_key && !prs.cancel_key && !prs.set_key && st_q == KMN_ST_DATA && live_edit)
    |=> op_write && op_value == $past(edit_q) + 1'b1)
    else $error("live edit not applied");

  a_code_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (prs.up_key && !prs.cancel_key && !prs.set_key && st_q == KMN_ST_CODE
     && code_q.item < KMN_ITEMS_PER_GROUP - 4'h1 && !lvl.cancel_key)
    |=> code_q.item == $past(code_q.item) + 4'h1)
    else $error("up did not step code");
endmodule
`default_nettype wire

/* File: verilog/kmn_pkg.sv */
package kmn_pkg;

  // ********************************
  // code layout
  // ********************************
  // group is the leftmost character of the four-character code
  typedef enum logic [3:0] {
    KMN_GRP_MON,   // monitor items, read-only
    KMN_GRP_MAIN,  // main profile
    KMN_GRP_STD,   // standard functions
    KMN_GRP_TUNE,  // fine tuning
    KMN_GRP_TERM,  // intelligent terminals
    KMN_GRP_MOTOR, // motor constants
    KMN_GRP_COMM,  // pulse, torque, communication
    KMN_GRP_USER   // user selected
  } kmn_group_t;

  localparam int KMN_NUM_GROUPS = 8;
  localparam int KMN_IDX_W = 12;   // three trailing digits, bcd
  localparam int KMN_DATA_W = 16;  // four displayed digits, binary value
  localparam int KMN_ADDR_W = 7;   // group and item index into value store
  localparam int KMN_ITEM_W = 4;   // item index bits, 16 slots per group in value store

  // number of items per group (last valid index + 1), plain defaults
  localparam logic [KMN_ITEM_W-1:0] KMN_ITEMS_PER_GROUP = 4'h8;
  // index of the first item of each group
  localparam logic [KMN_ITEM_W-1:0] KMN_FIRST_ITEM = 4'h1;
  // main-profile item that does not take effect live
  localparam logic [KMN_ITEM_W-1:0] KMN_EXCLUDED_ITEM = 4'h4;
  localparam logic [KMN_DATA_W-1:0] KMN_DATA_RST = 16'h0000;

  // ********************************
  // timing
  // ********************************
  localparam longint KMN_CLK_HZ = 40_000_000;
  localparam longint KMN_HOLD_MS = 1000;   // cancel hold time
  localparam longint KMN_HOLD_CYC = (KMN_CLK_HZ * KMN_HOLD_MS + 999) / 1000;
  localparam int KMN_HOLD_W = 26;

  // ********************************
  // carriers
  // ********************************
  typedef struct packed {
    logic cancel_key; // cancel
    logic set_key;    // set and store
    logic up_key;     // increment
    logic down_key;   // decrement
  } kmn_keys_t;

  typedef struct packed {
    kmn_group_t group;               // leftmost character class
    logic [KMN_ITEM_W-1:0] item;     // item within group
  } kmn_code_t;

endpackage

/* File: verilog/kmn_key_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module kmn_key_edge (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // raw key pins
  input wire kmn_pkg::kmn_keys_t keys_pin,
  // synchronised levels and press pulses
  output kmn_pkg::kmn_keys_t keys_level,
  output kmn_pkg::kmn_keys_t keys_press
);
  import kmn_pkg::*;

  // ********************************
  // two-stage synchroniser and edge
  // ********************************
  logic [3:0] s1_q, s1_d;
  logic [3:0] s2_q, s2_d;
  logic [3:0] s3_q, s3_d;   // previous level, for edge detect

  // next values: first stage only feeds the second
  always_comb begin
    s1_d = keys_pin;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  assign keys_level = s2_q;
  assign keys_press = s2_q & ~s3_q;
endmodule
`default_nettype wire

/* File: verification/kmn_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ********************************
// front-panel key model
// ********************************
// a request of one cycle becomes a clean press: key held for six cycles, then
// released for six, so the synchroniser always sees a full press and release
module kmn_panel_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // request from the bench, one cycle wide
  input wire kmn_pkg::kmn_keys_t press_req,
  // key pins toward the design
  output kmn_pkg::kmn_keys_t keys_pin,
  output logic busy
);
  import kmn_pkg::*;

  kmn_keys_t key_q, key_d; // key being pressed
  logic [3:0] cnt_q, cnt_d; // press phase, 0 means idle

  // next press phase; new requests are ignored while a press runs
  always_comb begin
    key_d = key_q;
    cnt_d = cnt_q;
    if (cnt_q == 4'h0) begin
      if (press_req != '0) begin
        key_d = press_req;
        cnt_d = 4'h1;
      end
    end else if (cnt_q == 4'hC) begin
      cnt_d = 4'h0;
    end else begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  // phase registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      key_q <= '0;
      cnt_q <= 4'h0;
    end else begin
      key_q <= key_d;
      cnt_q <= cnt_d;
    end
  end

  // pins are high only in the first half of a press
  assign keys_pin = (cnt_q != 4'h0 && cnt_q <= 4'h6) ? key_q : '0;
  assign busy = (cnt_q != 4'h0);
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define chk(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected %s expected %0h seen %0h", what, exp, got); end end
module tb;
  import kmn_pkg::*;
  // ********************************
  // stimulus and observation
  // ********************************
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  kmn_keys_t press_req = '0; // one-cycle key request
  logic [KMN_DATA_W-1:0] monitor_value = 16'h1234; // value seen in monitor view
  kmn_keys_t keys_pin;
  logic busy;
  kmn_code_t disp_code;
  logic disp_is_data;
  logic [KMN_DATA_W-1:0] disp_value;
  logic program_mode_indicator;
  logic [KMN_ADDR_W-1:0] op_addr;
  logic [KMN_DATA_W-1:0] op_value;
  logic op_write;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_wr = 0; // op_write pulses seen
  int w0; // pulse count before a step
  logic [KMN_ADDR_W-1:0] last_addr = '0; // address of the last pulse
  logic [KMN_DATA_W-1:0] last_val = '0; // value of the last pulse
  localparam kmn_keys_t K_CAN = 4'h8;
  localparam kmn_keys_t K_SET = 4'h4;
  localparam kmn_keys_t K_UP = 4'h2;
  localparam kmn_keys_t K_DN = 4'h1;

  always #12.5 clk_sys = ~clk_sys;

  kmn_panel_model panel_u (.clk_sys(clk_sys), .rst_n(rst_n), .press_req(press_req),
    .keys_pin(keys_pin), .busy(busy));
  kmn_navigator dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .keys_pin(keys_pin),
    .monitor_value(monitor_value), .disp_code(disp_code), .disp_is_data(disp_is_data),
    .disp_value(disp_value), .program_mode_indicator(program_mode_indicator),
    .op_addr(op_addr), .op_value(op_value), .op_write(op_write));

  // count every pulse so silent writes are caught too
  always @(posedge clk_sys) begin
    if (op_write === 1'b1) begin
      n_wr++;
      last_addr <= op_addr;
      last_val <= op_value;
    end
  end

  // ********************************
  // shared tasks
  // ********************************
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one full press and release, then let the answer settle
  task automatic press(input kmn_keys_t k);
    int w;
    @(posedge clk_sys);
    press_req <= k;
    @(posedge clk_sys);
    press_req <= '0;
    #1;
    w = 0;
    while (busy === 1'b1 && w < 40) begin
      @(posedge clk_sys);
      w++;
    end
    #1;
  endtask

  task automatic chk_view(input kmn_group_t g, input logic [3:0] i, input logic d);
    `chk("disp_code", kmn_code_t'{g, i}, disp_code)
    `chk("program_mode_indicator", (g != KMN_GRP_MON), program_mode_indicator)
    `chk("disp_is_data", d, disp_is_data)
  endtask

  // ********************************
  // scenarios
  // ********************************
  task automatic t_reset;
    chk_view(KMN_GRP_MON, KMN_FIRST_ITEM, 1'b0);
    `chk("op_write count", 0, n_wr)
  endtask

  task automatic t_code_step;
    press(K_UP);
    chk_view(KMN_GRP_MON, 4'h2, 1'b0);
    press(K_DN);
    chk_view(KMN_GRP_MON, 4'h1, 1'b0);
  endtask

  // monitor values may be viewed but never changed or stored
  task automatic t_monitor;
    w0 = n_wr;
    press(K_SET);
    chk_view(KMN_GRP_MON, 4'h1, 1'b1);
    `chk("disp_value", 16'h1234, disp_value)
    press(K_UP);
    `chk("disp_value", 16'h1234, disp_value)
    press(K_SET);
    chk_view(KMN_GRP_MON, 4'h1, 1'b0);
    `chk("op_write count", w0, n_wr)
  endtask

  // repeated cancel walks every group and wraps back to monitor
  task automatic t_groups;
    for (int g = 1; g <= KMN_NUM_GROUPS; g++) begin
      press(K_CAN);
      chk_view(kmn_group_t'(g % KMN_NUM_GROUPS), KMN_FIRST_ITEM, 1'b0);
    end
  endtask

  task automatic t_main_live;
    press(K_CAN);
    press(K_SET);
    chk_view(KMN_GRP_MAIN, KMN_FIRST_ITEM, 1'b1);
    w0 = n_wr;
    press(K_UP);
    `chk("op_write count", w0 + 1, n_wr)
    `chk("op_addr", 7'h11, last_addr)
    `chk("op_value", 16'h0001, last_val)
    `chk("disp_value", 16'h0001, disp_value)
    press(K_CAN);
    chk_view(KMN_GRP_MAIN, KMN_FIRST_ITEM, 1'b0);
    `chk("op_write count", w0 + 2, n_wr)
    `chk("op_value", 16'h0000, last_val)
  endtask

  // the excluded item only takes effect when stored
  task automatic t_excluded;
    repeat (3) press(K_UP);
    chk_view(KMN_GRP_MAIN, KMN_EXCLUDED_ITEM, 1'b0);
    press(K_SET);
    w0 = n_wr;
    press(K_UP);
    `chk("op_write count", w0, n_wr)
    press(K_SET);
    `chk("op_write count", w0 + 1, n_wr)
    `chk("op_addr", 7'h14, last_addr)
    `chk("op_value", 16'h0001, last_val)
    chk_view(KMN_GRP_MAIN, KMN_EXCLUDED_ITEM, 1'b0);
  endtask

  // an abandoned edit in a non-live group writes nothing
  task automatic t_std_cancel;
    press(K_CAN);
    chk_view(KMN_GRP_STD, KMN_FIRST_ITEM, 1'b0);
    press(K_SET);
    w0 = n_wr;
    press(K_UP);
    press(K_CAN);
    `chk("op_write count", w0, n_wr)
    chk_view(KMN_GRP_STD, KMN_FIRST_ITEM, 1'b0);
    press(K_SET);
    `chk("disp_value", 16'h0000, disp_value)
    press(K_CAN);
  endtask

  // ********************************
  // main sequence and watchdog
  // ********************************
  // the one-second cancel hold is 40e6 cycles, far beyond this run's budget
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    t_reset;
    t_code_step;
    t_monitor;
    t_groups;
    t_main_live;
    t_excluded;
    t_std_cancel;
    end_of_test;
  end

  // about thirty presses of fifteen cycles each, with wide margin
  initial begin
    #(25 * 5000);
    n_mismatch++;
    end_of_test;
  end
endmodule
`default_nettype wire
